//--- rtl/pmc_pkg.sv
// package of the power mode controller: modes, timing, carriers
// assumes a 10 MHz cpu clock and synchronous pin inputs
`default_nettype none
package pmc_pkg;

	// ****************************************************************
	// constants
	// ****************************************************************
	localparam int CLK_PERIOD_NS = 100;
	localparam int WAKE_PULSE_NS = 40;
	localparam int WAKE_PULSE_CYC = (WAKE_PULSE_NS + CLK_PERIOD_NS - 1) /
		CLK_PERIOD_NS < 1 ? 1 : (WAKE_PULSE_NS + CLK_PERIOD_NS - 1) /
		CLK_PERIOD_NS;
	localparam int WAKE_CFG_POS = 5;
	localparam int NUM_FAST_IRQ = 8;
	localparam logic STANDBY_RAM_EN_RST = 1'h0;
	localparam logic LP_OSC_SEL_RST = 1'h0;
	localparam logic STANDBY_SEL_RST = 1'h1;
	localparam logic DIP_HOLD_RST = 1'h0;

	// ****************************************************************
	// types
	// ****************************************************************
	typedef enum logic [2:0] {
		ST_RUN = 3'h0,
		ST_DRAIN = 3'h1,
		ST_IDLE = 3'h2,
		ST_PD_PROT = 3'h3,
		ST_PD_INT = 3'h4
	} mode_t;

	typedef enum logic [1:0] {
		REQ_NONE = 2'h0,
		REQ_IDLE = 2'h1,
		REQ_PD = 2'h2
	} req_t;

	// wake sources of interruptible power-down
	typedef struct packed {
		logic [NUM_FAST_IRQ-1:0] fast_irq;
		logic rtc_irq;
		logic can_irq;
		logic i2c_irq;
	} wake_src_t;

	// gating outputs toward the clock tree and oscillators
	typedef struct packed {
		logic cpu_run;
		logic periph_run;
		logic wdt_run;
		logic main_osc_run;
		logic rtc_run;
	} gate_t;

endpackage : pmc_pkg
`default_nettype wire

//--- rtl/power_mode_controller.sv
// power mode controller: idle, power-down, standby ram guard
// assumes pins synchronous to clock_i; reset_n_i is the device reset
// Notes on behaviour
// - idle stops cpu, peripherals keep running
// - power-down stops cpu and all peripherals
// - modes start only by protected instructions
// - pending external bus cycle finishes first
// - refuse entry if enabled ready missed
// - any interrupt ends idle, resume after
// - power-down stops clock and watchdog too
// - low-power oscillator selected stops main oscillator in power-down
// - main oscillator only stays on for rtc
// - low-power oscillator adopted once detected, kept until disabled
// - wake config bit zero selects protected
// - protected entry needs nmi pin low
// - protected exit only by external reset
// - wake config bit one selects interruptible
// - interruptible entry needs enabled pins inactive
// - interruptible wakes on reset, pin, rtc, bus
// - in reset ram disabled and frozen
// - clearing enable freezes ram until set
// - reset switches ram onto standby supply
// - collapsing supply keeps ram frozen regardless
// - enable set, supply dip causes no switch
`timescale 1ns/1ps
`default_nettype none
module power_mode_controller #(
	parameter int NUM_IRQ = pmc_pkg::NUM_FAST_IRQ
) (
	input wire logic clock_i,
	input wire logic reset_n_i,
	input wire pmc_pkg::req_t instr_req_i,
	input wire logic bus_busy_i,
	input wire logic ready_en_i,
	input wire logic ready_pol_i,
	input wire logic ready_last_i,
	input wire logic [7:0] system_config_register_i,
	input wire logic regulator_shutdown_bit_i,
	input wire logic nmi_n_i,
	input wire logic irq_req_i,
	input wire logic return_from_interrupt_instr_i,
	input wire logic [NUM_IRQ-1:0] fast_irq_en_i,
	input wire logic [NUM_IRQ-1:0] fast_irq_pol_i,
	input wire pmc_pkg::wake_src_t wake_i,
	input wire logic lp_osc_present_i,
	input wire logic lp_osc_disable_i,
	input wire logic ram_en_set_i,
	input wire logic ram_en_clr_i,
	input wire logic core_ok_i,
	output pmc_pkg::mode_t mode_o,
	output pmc_pkg::gate_t gate_o,
	output logic req_refused_o,
	output logic resume_next_o,
	output logic lp_osc_sel_o,
	output logic ram_en_o,
	output logic ram_frozen_o,
	output logic ram_on_standby_o
);
	import pmc_pkg::*;

	// refuse pin counts that the wake carrier cannot hold
	generate
		if (NUM_IRQ < 1 || NUM_IRQ > NUM_FAST_IRQ) begin : g_bad_irq
			$error("NUM_IRQ out of range");
		end
	endgenerate

	mode_t mode_r;
	mode_t mode_nxt;
	req_t pend_r;
	logic refused_r;
	logic resume_r;
	logic lp_sel_r;
	gate_t gate_r;
	logic [NUM_IRQ-1:0] pin_act;
	logic ready_ok;
	logic pins_quiet;
	logic any_wake;
	logic wake_cfg;

	// ****************************************************************
	// entry qualifiers
	// ****************************************************************
	// active level of each fast interrupt pin
	generate
		for (genvar i = 0; i < NUM_IRQ; i++) begin : g_pin
			assign pin_act[i] = fast_irq_en_i[i] &&
				(wake_i.fast_irq[i] == fast_irq_pol_i[i]);
		end
	endgenerate

	assign ready_ok = !ready_en_i || (ready_last_i == ready_pol_i);
	assign pins_quiet = ~|pin_act;
	assign wake_cfg = system_config_register_i[WAKE_CFG_POS];
	// a pin counts at one sampled cycle, which covers the 40 ns pulse
	assign any_wake = |pin_act || wake_i.rtc_irq || wake_i.can_irq ||
		wake_i.i2c_irq;

	// ****************************************************************
	// mode controller
	// ****************************************************************
	// next mode
	always_comb begin
		mode_nxt = mode_r;
		unique case (mode_r)
			ST_RUN: begin
				if (instr_req_i != REQ_NONE)
					mode_nxt = ST_DRAIN;
			end
			ST_DRAIN: begin
				if (!bus_busy_i) begin
					if (!ready_ok)
						mode_nxt = ST_RUN;
					else if (pend_r == REQ_IDLE)
						mode_nxt = ST_IDLE;
					else if (!wake_cfg && !nmi_n_i)
						mode_nxt = ST_PD_PROT;
					else if (wake_cfg && pins_quiet)
						mode_nxt = ST_PD_INT;
					else
						mode_nxt = ST_RUN;
				end
			end
			ST_IDLE: begin
				if (irq_req_i)
					mode_nxt = ST_RUN;
			end
			ST_PD_PROT: begin
				mode_nxt = ST_PD_PROT;
			end
			ST_PD_INT: begin
				if (any_wake)
					mode_nxt = ST_RUN;
			end
			default: mode_nxt = ST_RUN;
		endcase
	end

	// state register, reset leaves every power-down
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			mode_r <= ST_RUN;
		end else begin
			mode_r <= mode_nxt;
		end
	end

	// captured request kind
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pend_r <= REQ_NONE;
		end else if (mode_r == ST_RUN) begin
			pend_r <= instr_req_i;
		end
	end

	// refusal flag: pulse when drain ends back in run
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			refused_r <= 1'h0;
		end else begin
			refused_r <= (mode_r == ST_DRAIN) && !bus_busy_i &&
				(mode_nxt == ST_RUN);
		end
	end

	// resume after idle: held until the interrupt return completes
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			resume_r <= 1'h0;
		end else if (mode_r == ST_IDLE && irq_req_i) begin
			resume_r <= 1'h1;
		end else if (return_from_interrupt_instr_i) begin
			resume_r <= 1'h0;
		end
	end

	// rtc reference: low-power oscillator latched once seen
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			lp_sel_r <= LP_OSC_SEL_RST;
		end else if (lp_osc_present_i) begin
			lp_sel_r <= 1'h1;
		end else if (lp_osc_disable_i) begin
			lp_sel_r <= 1'h0;
		end
	end

	// ****************************************************************
	// clock gating
	// ****************************************************************
	// registered gates from the next mode
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			gate_r <= '{cpu_run: 1'h1, periph_run: 1'h1, wdt_run: 1'h1,
				main_osc_run: 1'h1, rtc_run: 1'h1};
		end else begin
			gate_r.cpu_run <= (mode_nxt == ST_RUN) ||
				(mode_nxt == ST_DRAIN);
			gate_r.periph_run <= (mode_nxt == ST_RUN) ||
				(mode_nxt == ST_DRAIN) || (mode_nxt == ST_IDLE);
			gate_r.wdt_run <= (mode_nxt == ST_RUN) ||
				(mode_nxt == ST_DRAIN) || (mode_nxt == ST_IDLE);
			gate_r.main_osc_run <= !((mode_nxt == ST_PD_PROT ||
				mode_nxt == ST_PD_INT) && lp_sel_r);
			gate_r.rtc_run <= 1'h1; // rtc keeps counting
		end
	end

	assign mode_o = mode_r;
	assign gate_o = gate_r;
	assign req_refused_o = refused_r;
	assign resume_next_o = resume_r;
	assign lp_osc_sel_o = lp_sel_r;

	// software is expected to have set regulator_shutdown_bit_i
	logic reg_unused;
	assign reg_unused = regulator_shutdown_bit_i;

	// ****************************************************************
	// retained ram guard
	// ****************************************************************
	ram_guard u_ram_guard (
		.clock_i(clock_i),
		.reset_n_i(reset_n_i),
		.ram_en_set_i(ram_en_set_i),
		.ram_en_clr_i(ram_en_clr_i),
		.core_ok_i(core_ok_i),
		.ram_en_o(ram_en_o),
		.ram_frozen_o(ram_frozen_o),
		.ram_on_standby_o(ram_on_standby_o)
	);

	// ****************************************************************
	// checks
	// ****************************************************************
	sequence s_drain_done;
		mode_r == ST_DRAIN && !bus_busy_i;
	endsequence

	property p_entry_by_instr;
		@(posedge clock_i) disable iff (!reset_n_i)
		mode_r == ST_RUN && instr_req_i == REQ_NONE |=> mode_r == ST_RUN;
	endproperty
	a_entry_by_instr: assert property (p_entry_by_instr)
		else $error("mode left run without instruction");

	property p_bus_drains;
		@(posedge clock_i) disable iff (!reset_n_i)
		mode_r == ST_DRAIN && bus_busy_i |=> mode_r == ST_DRAIN;
	endproperty
	a_bus_drains: assert property (p_bus_drains)
		else $error("mode changed during busy bus cycle");

	property p_ready_refuse;
		@(posedge clock_i) disable iff (!reset_n_i)
		s_drain_done ##0 !ready_ok |=> mode_r == ST_RUN ##0 req_refused_o;
	endproperty
	a_ready_refuse: assert property (p_ready_refuse)
		else $error("entry not refused on missed ready");

	property p_idle_gates;
		@(posedge clock_i) disable iff (!reset_n_i)
		mode_r == ST_IDLE && $past(mode_r) == ST_IDLE |->
			!gate_o.cpu_run && gate_o.periph_run;
	endproperty
	a_idle_gates: assert property (p_idle_gates)
		else $error("idle gating wrong");

	property p_idle_wake;
		@(posedge clock_i) disable iff (!reset_n_i)
		mode_r == ST_IDLE && irq_req_i |=> mode_r == ST_RUN && resume_next_o;
	endproperty
	a_idle_wake: assert property (p_idle_wake)
		else $error("idle not ended by interrupt");

	property p_pd_gates;
		@(posedge clock_i) disable iff (!reset_n_i)
		mode_nxt == ST_PD_INT |=> !gate_o.cpu_run && !gate_o.periph_run &&
			!gate_o.wdt_run;
	endproperty
	a_pd_gates: assert property (p_pd_gates)
		else $error("power-down gating wrong");

	property p_prot_hold;
		@(posedge clock_i) disable iff (!reset_n_i)
		mode_r == ST_PD_PROT |=> mode_r == ST_PD_PROT;
	endproperty
	a_prot_hold: assert property (p_prot_hold)
		else $error("protected power-down left without reset");

	property p_prot_needs_nmi;
		@(posedge clock_i) disable iff (!reset_n_i)
		s_drain_done ##0 nmi_n_i |=> mode_r != ST_PD_PROT;
	endproperty
	a_prot_needs_nmi: assert property (p_prot_needs_nmi)
		else $error("protected entry with nmi high");

	property p_int_wake;
		@(posedge clock_i) disable iff (!reset_n_i)
		mode_r == ST_PD_INT && any_wake |=> mode_r == ST_RUN;
	endproperty
	a_int_wake: assert property (p_int_wake)
		else $error("interruptible power-down missed wake");

	property p_int_quiet;
		@(posedge clock_i) disable iff (!reset_n_i)
		s_drain_done ##0 !pins_quiet |=> mode_r != ST_PD_INT;
	endproperty
	a_int_quiet: assert property (p_int_quiet)
		else $error("interruptible entry with active pin");

endmodule : power_mode_controller
`default_nettype wire

//--- rtl/ram_guard.sv
// retained ram freeze and supply switch
// assumes reset_n_i is the device reset and core_ok_i the supply monitor
`timescale 1ns/1ps
`default_nettype none
module ram_guard (
	input wire logic clock_i,
	input wire logic reset_n_i,
	input wire logic ram_en_set_i,
	input wire logic ram_en_clr_i,
	input wire logic core_ok_i,
	output logic ram_en_o,
	output logic ram_frozen_o,
	output logic ram_on_standby_o
);
	import pmc_pkg::*;

	logic ram_en_r;
	logic stby_r;
	logic dip_hold_r;

	// ****************************************************************
	// enable bit
	// ****************************************************************
	// cleared in reset, set only by software
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			ram_en_r <= STANDBY_RAM_EN_RST;
		end else if (ram_en_clr_i) begin
			ram_en_r <= 1'h0;
		end else if (ram_en_set_i) begin
			ram_en_r <= 1'h1;
		end
	end

	// supply selection: standby from reset until core is up again
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			stby_r <= STANDBY_SEL_RST;
		end else if (core_ok_i) begin
			stby_r <= 1'h0;
		end
	end

	// a collapse that starts while disabled keeps the freeze until core is up
	always_ff @(posedge clock_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			dip_hold_r <= DIP_HOLD_RST;
		end else begin
			dip_hold_r <= !core_ok_i && (dip_hold_r || !ram_en_r);
		end
	end

	// freeze: enable cleared, in reset, or supply collapsing while disabled
	assign ram_frozen_o = !reset_n_i || !ram_en_r || dip_hold_r;
	// a dip with the bit set leaves the ram on the core supply
	assign ram_on_standby_o = stby_r ||
		(!core_ok_i && (!ram_en_r || dip_hold_r));
	assign ram_en_o = ram_en_r;

	// ****************************************************************
	// checks
	// ****************************************************************
	sequence s_dip_onset;
		ram_en_r && core_ok_i && !ram_en_clr_i ##1 !core_ok_i;
	endsequence

	property p_dip_no_freeze;
		@(posedge clock_i) disable iff (!reset_n_i)
		s_dip_onset |-> !ram_frozen_o && !ram_on_standby_o;
	endproperty
	a_dip_no_freeze: assert property (p_dip_no_freeze)
		else $error("ram frozen on supply dip with enable set");

	property p_clr_freezes;
		@(posedge clock_i) disable iff (!reset_n_i)
		ram_en_clr_i || (!ram_en_r && !ram_en_set_i) |=> ram_frozen_o;
	endproperty
	a_clr_freezes: assert property (p_clr_freezes)
		else $error("ram not frozen after enable cleared");

	property p_dip_keeps_frozen;
		@(posedge clock_i) disable iff (!reset_n_i)
		ram_frozen_o && !core_ok_i |=> ram_frozen_o;
	endproperty
	a_dip_keeps_frozen: assert property (p_dip_keeps_frozen)
		else $error("ram freeze lost during supply collapse");

endmodule : ram_guard
`default_nettype wire

//--- sim/pmc_partner.sv
// partner model: cpu software issuing instructions, fast wake pins
// assumes the bench calls its tasks and drives nothing it owns
`timescale 1ns/1ps
`default_nettype none
module pmc_partner (
	input wire logic clock_i,
	output pmc_pkg::req_t instr_req_o,
	output logic regulator_shutdown_bit_o,
	output logic [pmc_pkg::NUM_FAST_IRQ-1:0] pin_o
);
	import pmc_pkg::*;
	// ****************************************************************
	// software and pin drivers
	// ****************************************************************
	// idle state of the software side
	initial begin
		instr_req_o = REQ_NONE;
		regulator_shutdown_bit_o = 1'h0;
		pin_o = '0;
	end
	// shutdown bit goes up one cycle ahead of the power-down request
	task automatic issue(input req_t r);
		@(posedge clock_i);
		regulator_shutdown_bit_o <= (r == REQ_PD);
		@(posedge clock_i);
		instr_req_o <= r;
		@(posedge clock_i);
		instr_req_o <= REQ_NONE;
	endtask : issue
	// static pin levels
	task automatic set_pins(input logic [NUM_FAST_IRQ-1:0] v);
		@(posedge clock_i);
		pin_o <= v;
	endtask : set_pins
	// wake pulse held for the minimum width, then released
	task automatic wake_pin(input int i, input logic lvl);
		@(posedge clock_i);
		pin_o[i] <= lvl;
		repeat (WAKE_PULSE_CYC) @(posedge clock_i);
		pin_o[i] <= ~lvl;
	endtask : wake_pin
endmodule : pmc_partner
`default_nettype wire

//--- sim/power_mode_controller_test.sv
// testbench of the power mode controller, random entries and wakes
// assumes pmc_pkg and the partner model are compiled first
`timescale 1ns/1ps
`default_nettype none
module power_mode_controller_test;
	import pmc_pkg::*;
	// ****************************************************************
	// signals and instances
	// ****************************************************************
	logic clock_i = 1'h0;
	logic reset_n_i = 1'h0;
	req_t req;
	logic reg_off, busy = 1'h0, r_en = 1'h0, r_pol = 1'h0, r_last = 1'h0;
	logic [7:0] cfg = 8'h00, pins, fen = 8'h00, fpol = 8'h00;
	logic nmi_n = 1'h1, irq = 1'h0, irq_ret = 1'h0, lp_on = 1'h0;
	logic lp_off = 1'h0, set = 1'h0, clr = 1'h0, core_ok = 1'h1;
	logic [2:0] side_w = 3'h0;
	wake_src_t wake;
	mode_t mode;
	gate_t gate;
	logic refused, resume, lp_sel, ram_en, frozen, stby, exp_lp;
	logic [31:0] seed = 32'h8D58;
	int bad_count = 0, comparisons = 0;
	assign wake = {pins, side_w};
	// clock and watchdog
	always #50 clock_i = ~clock_i;
	initial begin
		#500000;
		bad_count++;
		close_out();
	end
	pmc_partner u_pmc_partner (.clock_i(clock_i), .instr_req_o(req),
		.regulator_shutdown_bit_o(reg_off), .pin_o(pins));
	power_mode_controller u_power_mode_controller (.clock_i(clock_i),
		.reset_n_i(reset_n_i), .instr_req_i(req), .bus_busy_i(busy),
		.ready_en_i(r_en), .ready_pol_i(r_pol), .ready_last_i(r_last),
		.system_config_register_i(cfg), .regulator_shutdown_bit_i(reg_off),
		.nmi_n_i(nmi_n), .irq_req_i(irq),
		.return_from_interrupt_instr_i(irq_ret),
		.fast_irq_en_i(fen), .fast_irq_pol_i(fpol), .wake_i(wake),
		.lp_osc_present_i(lp_on), .lp_osc_disable_i(lp_off),
		.ram_en_set_i(set), .ram_en_clr_i(clr), .core_ok_i(core_ok),
		.mode_o(mode), .gate_o(gate), .req_refused_o(refused),
		.resume_next_o(resume), .lp_osc_sel_o(lp_sel), .ram_en_o(ram_en),
		.ram_frozen_o(frozen), .ram_on_standby_o(stby));
	// ****************************************************************
	// helpers
	// ****************************************************************
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr
	// expected mode after an accepted or refused request
	function automatic mode_t exp_mode(input req_t r);
		if (r_en && r_last !== r_pol)
			return ST_RUN;
		if (r == REQ_IDLE)
			return ST_IDLE;
		if (!cfg[WAKE_CFG_POS])
			return nmi_n ? ST_RUN : ST_PD_PROT;
		return |(fen & ~(pins ^ fpol)) ? ST_RUN : ST_PD_INT;
	endfunction : exp_mode
	function automatic gate_t exp_gate(input mode_t m, input logic lp);
		if (m == ST_IDLE)
			return 5'h0F;
		if (m == ST_PD_PROT || m == ST_PD_INT)
			return {3'h0, ~lp, 1'h1};
		return 5'h1F;
	endfunction : exp_gate
	task automatic check(input string name, input logic [31:0] seen, exp);
		comparisons++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic close_out();
		if (bad_count == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : close_out
	task automatic edge_n(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask : edge_n
	// reset held 9 cycles, values checked while held after the eighth
	task automatic do_reset();
		@(posedge clock_i);
		reset_n_i <= 1'h0;
		lp_on <= 1'h0;
		edge_n(8);
		check("mode_rst", {mode, gate}, {ST_RUN, 5'h1F});
		check("ram_rst", {refused, resume, lp_sel, ram_en, frozen, stby},
			6'h03);
		@(posedge clock_i);
		reset_n_i <= 1'h1;
		exp_lp = 1'h0;
	endtask : do_reset
	task automatic ram_step(input logic s, c, ok, input logic [1:0] e);
		@(posedge clock_i);
		{set, clr, core_ok} <= {s, c, ok};
		@(posedge clock_i);
		{set, clr} <= 2'h0;
		#1;
		check("ram_en_frozen", {ram_en, frozen}, e);
	endtask : ram_step
	// one random entry, then the wake that suits the reached mode
	task automatic one_round();
		req_t r;
		mode_t m;
		int i;
		repeat (32) seed = lfsr(seed);
		r = seed[31] ? REQ_PD : REQ_IDLE;
		@(posedge clock_i);
		{r_en, r_pol, r_last} <= {seed[0] & seed[1], seed[2], seed[3]};
		{cfg, nmi_n, fen, fpol} <= {seed[11:4], seed[12], seed[20:13],
			seed[28:21]};
		{busy, lp_on} <= seed[30:29];
		u_pmc_partner.set_pins(~seed[28:21] ^ (seed[7:0] & seed[15:8]));
		u_pmc_partner.issue(r);
		m = exp_mode(r);
		exp_lp = exp_lp | lp_on;
		if (busy) begin
			edge_n(2);
			check("drain", mode, ST_DRAIN);
			@(posedge clock_i);
			busy <= 1'h0;
		end
		edge_n(1);
		check("mode", mode, m);
		check("refused", refused, m == ST_RUN);
		check("gate", gate, exp_gate(m, exp_lp));
		check("lp_sel", lp_sel, exp_lp);
		if (m == ST_IDLE) begin
			@(posedge clock_i);
			irq <= 1'h1;
			@(posedge clock_i);
			irq <= 1'h0;
			#1;
			check("idle_wake", {mode, resume}, {ST_RUN, 1'h1});
			@(posedge clock_i);
			irq_ret <= 1'h1;
			@(posedge clock_i);
			irq_ret <= 1'h0;
			#1;
			check("resume", resume, 1'h0);
		end else if (m == ST_PD_INT) begin
			if (fen != 8'h00 && seed[5]) begin
				i = 0;
				while (!fen[i])
					i++;
				u_pmc_partner.wake_pin(i, fpol[i]);
			end else begin
				@(posedge clock_i);
				side_w <= 3'h1 << (seed[7:6] % 2'h3);
				@(posedge clock_i);
				side_w <= 3'h0;
			end
			#1;
			check("pd_wake", mode, ST_RUN);
		end else if (m == ST_PD_PROT) begin
			@(posedge clock_i);
			{irq, side_w} <= 4'hF;
			edge_n(3);
			check("prot_hold", mode, ST_PD_PROT);
			@(posedge clock_i);
			{irq, side_w} <= 4'h0;
			do_reset();
		end else begin
			edge_n(3);
			check("no_entry", mode, ST_RUN);
		end
	endtask : one_round
	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		do_reset();
		edge_n(1);
		check("standby_off", stby, 1'h0);
		ram_step(1'h1, 1'h0, 1'h1, 2'h2);
		ram_step(1'h0, 1'h0, 1'h0, 2'h2);
		check("dip_standby", stby, 1'h0);
		ram_step(1'h0, 1'h1, 1'h1, 2'h1);
		ram_step(1'h1, 1'h1, 1'h1, 2'h1);
		ram_step(1'h1, 1'h0, 1'h0, 2'h3);
		check("dip_frozen_standby", stby, 1'h1);
		ram_step(1'h1, 1'h0, 1'h1, 2'h2);
		@(posedge clock_i);
		lp_on <= 1'h1;
		@(posedge clock_i);
		lp_on <= 1'h0;
		edge_n(1);
		check("lp_kept", lp_sel, 1'h1);
		@(posedge clock_i);
		lp_off <= 1'h1;
		@(posedge clock_i);
		lp_off <= 1'h0;
		#1;
		check("lp_off", lp_sel, 1'h0);
		repeat (40) one_round();
		close_out();
	end
endmodule : power_mode_controller_test
`default_nettype wire
